// *** hdl/setwt_pkg.sv ***
// Shared constants and types of the two-wire serial memory target.
// Assumes a 100 MHz core clock and a free-running link sampling clock.
package setwt_pkg;
	// Widths
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 8;
	localparam int STRAP_W    = 3;
	localparam int PIN_W      = STRAP_W + 2;
	localparam int MEM_DEPTH  = 256;
	localparam int PAGE_W     = 3;
	localparam int FIFO_W     = ADDR_W + DATA_W;
	localparam int FIFO_DEPTH = 16;
	// Device address byte layout
	localparam int FAMILY_MSB = 7;
	localparam int FAMILY_LSB = 4;
	localparam int STRAP_MSB  = 3;
	localparam int STRAP_LSB  = 1;
	localparam int RW_BIT     = 0;
	localparam logic [3:0] FAMILY_CODE = 4'ha;
	localparam logic [3:0] BYTE_BITS   = 4'h8;
	// Internal write cycle timing
	localparam int INTERNAL_WRITE_CYCLE_TIME_NS = 5000000;
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int WR_CYCLES_DEF =
		INTERNAL_WRITE_CYCLE_TIME_NS / CLOCK_PERIOD_NS;
	localparam int TMR_W = $clog2(WR_CYCLES_DEF);

	typedef enum logic [3:0] {
		L_IDLE, L_DEV, L_DEV_ACK, L_WADDR, L_WADDR_ACK,
		L_WDATA, L_WDATA_ACK, L_RDATA, L_RD_ACK
	} setwt_link_st_type;

	typedef enum logic [1:0] {
		C_IDLE, C_DRAIN, C_WAIT, C_DONE
	} setwt_core_st_type;
endpackage

// *** hdl/setwt_stream_if.sv ***
// Valid/ready stream carrying words between the design's modules.
// Assumes both ends sit on the clock given by the module using each side.
`timescale 1ns/10ps
interface setwt_stream_if #(
	parameter int W = 16
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface // setwt_stream_if

// *** hdl/setwt_sync.sv ***
// Two flip-flop level synchroniser, one chain per bit.
// Assumes rst_n is already released in the clk domain (or is the raw reset).
`timescale 1ns/10ps
module setwt_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	////////////////////////////////////////////////////////////////////////
	// One chain per bit; first stage feeds only the second
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				meta_r[i] <= 1'b0;
				q_r[i]    <= 1'b0;
			end else begin
				meta_r[i] <= d[i];
				q_r[i]    <= meta_r[i];
			end
		end
	end

	assign q = q_r;
endmodule // setwt_sync

// *** hdl/setwt_fifo.sv ***
// Dual-clock FIFO with gray-coded pointers.
// Assumes DEPTH is a power of two, at least 4; each side has its own reset.
`timescale 1ns/10ps
module setwt_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 16
) (
	input  wire logic   wclk,
	input  wire logic   wrst_n,
	input  wire logic   rclk,
	input  wire logic   rrst_n,
	setwt_stream_if.snk wr,
	setwt_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_r [DEPTH];
	logic [AW:0]  wbin_r, wbin_nxt, wgray_r, wgray_nxt, rgray_w;
	logic [AW:0]  rbin_r, rbin_nxt, rgray_r, rgray_nxt, wgray_rd;
	logic         full, empty, push, pop;

	////////////////////////////////////////////////////////////////////////
	// Pointer crossings
	setwt_sync #(.W(AW + 1)) u_r2w (
		.clk   (wclk),
		.rst_n (wrst_n),
		.d     (rgray_r),
		.q     (rgray_w)
	);
	setwt_sync #(.W(AW + 1)) u_w2r (
		.clk   (rclk),
		.rst_n (rrst_n),
		.d     (wgray_r),
		.q     (wgray_rd)
	);

	// Flags and handshakes
	assign full     = wgray_r == {~rgray_w[AW:AW-1], rgray_w[AW-2:0]};
	assign empty    = rgray_r == wgray_rd;
	assign push     = wr.valid & ~full;
	assign pop      = rd.ready & ~empty;
	assign wr.ready = ~full;
	assign rd.valid = ~empty;
	assign rd.data  = mem_r[rbin_r[AW-1:0]];

	// Next pointers
	always_comb begin
		wbin_nxt  = wbin_r + {{AW{1'b0}}, push};
		wgray_nxt = wbin_nxt ^ (wbin_nxt >> 1);
		rbin_nxt  = rbin_r + {{AW{1'b0}}, pop};
		rgray_nxt = rbin_nxt ^ (rbin_nxt >> 1);
	end

	////////////////////////////////////////////////////////////////////////
	// Write side
	always_ff @(posedge wclk or negedge wrst_n) begin
		if (!wrst_n) begin
			wbin_r  <= '0;
			wgray_r <= '0;
		end else begin
			wbin_r  <= wbin_nxt;
			wgray_r <= wgray_nxt;
		end
	end

	// Storage has no reset
	always_ff @(posedge wclk) begin
		if (push) begin
			mem_r[wbin_r[AW-1:0]] <= wr.data;
		end
	end

	// Read side
	always_ff @(posedge rclk or negedge rrst_n) begin
		if (!rrst_n) begin
			rbin_r  <= '0;
			rgray_r <= '0;
		end else begin
			rbin_r  <= rbin_nxt;
			rgray_r <= rgray_nxt;
		end
	end
endmodule // setwt_fifo

// *** hdl/setwt_target.sv ***
// Two-wire serial memory target: link engine, page buffer, write cycle.
// Assumes scl/sda/straps are asynchronous pins, link_clk free-running and
// several times faster than scl.
`timescale 1ns/10ps
module setwt_target #(
	parameter int WR_CYCLES = setwt_pkg::WR_CYCLES_DEF
) (
	input  wire logic                         clock,
	input  wire logic                         resetn,
	input  wire logic                         link_clk,
	input  wire logic                         scl,
	input  wire logic                         sda_i,
	output logic                              sda_o,
	output logic                              sda_oe,
	input  wire logic [setwt_pkg::STRAP_W-1:0] device_select_straps,
	output logic                              write_busy
);
	import setwt_pkg::*;

	logic                    rst_n, lrst_n;
	logic [PIN_W-1:0]        pin_s;
	logic                    scl_s, sda_s;
	logic [STRAP_W-1:0]      straps_s;
	logic                    req_s, ack_s, busy;
	logic                    start, stop, scl_rise, scl_fall;
	logic                    in_byte, rx_done, match;
	logic [DATA_W-1:0]       rbyte;
	logic [DATA_W-1:0]       mem_r [MEM_DEPTH];
	// Link state
	setwt_link_st_type       lst_r, lst_nxt;
	logic [3:0]              cnt_r, cnt_nxt;
	logic [DATA_W-1:0]       sh_r, sh_nxt;
	logic [ADDR_W-1:0]       addr_r, addr_nxt;
	logic                    oe_r, oe_nxt, rw_r, rw_nxt;
	logic                    mack_r, mack_nxt, seen_r, seen_nxt;
	logic                    req_r, req_nxt, wv_r, wv_nxt;
	logic [FIFO_W-1:0]       wd_r, wd_nxt;
	logic                    scl_q_r, sda_q_r;
	// Core state
	setwt_core_st_type       cst_r, cst_nxt;
	logic [TMR_W-1:0]        tmr_r, tmr_nxt;
	logic                    cack_r, cack_nxt, busy_r, busy_nxt;

	setwt_stream_if #(.W(FIFO_W)) wr_if ();
	setwt_stream_if #(.W(FIFO_W)) rd_if ();

	////////////////////////////////////////////////////////////////////////
	// Reset release and crossings
	setwt_sync #(.W(1)) u_rst (
		.clk   (clock),
		.rst_n (resetn),
		.d     (1'b1),
		.q     (rst_n)
	);
	setwt_sync #(.W(1)) u_lrst (
		.clk   (link_clk),
		.rst_n (resetn),
		.d     (1'b1),
		.q     (lrst_n)
	);
	setwt_sync #(.W(PIN_W)) u_pins (
		.clk   (link_clk),
		.rst_n (lrst_n),
		.d     ({~scl, ~sda_i, device_select_straps}), // Idle high rests low
		.q     (pin_s)
	);
	setwt_sync #(.W(1)) u_req (
		.clk   (clock),
		.rst_n (rst_n),
		.d     (req_r),
		.q     (req_s)
	);
	setwt_sync #(.W(1)) u_ack (
		.clk   (link_clk),
		.rst_n (lrst_n),
		.d     (cack_r),
		.q     (ack_s)
	);

	// Page buffer from link to core
	setwt_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.wclk   (link_clk),
		.wrst_n (lrst_n),
		.rclk   (clock),
		.rrst_n (rst_n),
		.wr     (wr_if.snk),
		.rd     (rd_if.src)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus conditions on synchronised pins
	assign {scl_s, sda_s, straps_s} = pin_s ^ {2'b11, {STRAP_W{1'b0}}};
	assign start    = scl_s & scl_q_r & sda_q_r & ~sda_s;
	assign stop     = scl_s & scl_q_r & ~sda_q_r & sda_s;
	assign scl_rise = scl_s & ~scl_q_r;
	assign scl_fall = ~scl_s & scl_q_r;
	assign busy     = req_r | ack_s;
	assign rx_done  = scl_fall && cnt_r == BYTE_BITS;
	assign in_byte  = lst_r == L_DEV || lst_r == L_WADDR ||
		lst_r == L_WDATA || lst_r == L_RDATA;
	assign match = sh_r[FAMILY_MSB:FAMILY_LSB] == FAMILY_CODE &&
		sh_r[STRAP_MSB:STRAP_LSB] == straps_s;
	assign wr_if.valid = wv_r;
	assign wr_if.data  = wd_r;
	assign sda_o  = 1'b0;
	assign sda_oe = oe_r;

	// Link engine next state
	always_comb begin
		lst_nxt  = lst_r;
		cnt_nxt  = cnt_r;
		sh_nxt   = sh_r;
		addr_nxt = addr_r;
		oe_nxt   = oe_r;
		rw_nxt   = rw_r;
		mack_nxt = mack_r;
		seen_nxt = seen_r;
		req_nxt  = req_r & ~ack_s;
		wv_nxt   = 1'b0;
		wd_nxt   = wd_r;
		rbyte    = mem_r[addr_r];
		if (stop) begin
			lst_nxt = L_IDLE;
			oe_nxt  = 1'b0;
			if (seen_r) begin
				req_nxt  = 1'b1;
				seen_nxt = 1'b0;
			end
		end else if (start) begin
			if (!busy) begin
				lst_nxt = L_DEV;
				cnt_nxt = 4'h0;
				oe_nxt  = 1'b0;
			end
		end else begin
			if (scl_rise && in_byte && cnt_r != BYTE_BITS) begin
				sh_nxt  = {sh_r[DATA_W-2:0], sda_s};
				cnt_nxt = cnt_r + 4'h1;
			end
			case (lst_r)
			L_DEV: begin
				if (rx_done) begin
					if (match) begin
						lst_nxt = L_DEV_ACK;
						oe_nxt  = 1'b1;
						rw_nxt  = sh_r[RW_BIT];
					end else begin
						lst_nxt = L_IDLE;
					end
				end
			end
			L_DEV_ACK: begin
				if (scl_fall) begin
					cnt_nxt = 4'h0;
					if (rw_r) begin
						sh_nxt  = rbyte;
						oe_nxt  = ~rbyte[DATA_W-1];
						lst_nxt = L_RDATA;
					end else begin
						oe_nxt  = 1'b0;
						lst_nxt = L_WADDR;
					end
				end
			end
			L_WADDR: begin
				if (rx_done) begin
					addr_nxt = sh_r;
					oe_nxt   = 1'b1;
					lst_nxt  = L_WADDR_ACK;
				end
			end
			L_WADDR_ACK, L_WDATA_ACK: begin
				if (scl_fall) begin
					oe_nxt  = 1'b0;
					cnt_nxt = 4'h0;
					lst_nxt = L_WDATA;
				end
			end
			L_WDATA: begin
				if (rx_done) begin
					lst_nxt = L_WDATA_ACK;
					if (wr_if.ready) begin
						oe_nxt   = 1'b1;
						wv_nxt   = 1'b1;
						wd_nxt   = {addr_r, sh_r};
						addr_nxt = {addr_r[ADDR_W-1:PAGE_W],
							addr_r[PAGE_W-1:0] + 3'h1};
						seen_nxt = 1'b1;
					end
				end
			end
			L_RDATA: begin
				if (scl_fall) begin
					if (cnt_r == BYTE_BITS) begin
						oe_nxt   = 1'b0;
						addr_nxt = addr_r + 8'h1;
						mack_nxt = 1'b0;
						lst_nxt  = L_RD_ACK;
					end else begin
						oe_nxt = ~sh_r[DATA_W-1];
					end
				end
			end
			L_RD_ACK: begin
				if (scl_rise) begin
					mack_nxt = ~sda_s;
				end else if (scl_fall) begin
					if (mack_r) begin
						sh_nxt  = rbyte;
						oe_nxt  = ~rbyte[DATA_W-1];
						cnt_nxt = 4'h0;
						lst_nxt = L_RDATA;
					end else begin
						lst_nxt = L_IDLE;
					end
				end
			end
			default: lst_nxt = L_IDLE;
			endcase
		end
	end

	// Link engine registers
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			lst_r   <= L_IDLE;
			cnt_r   <= 4'h0;
			sh_r    <= 8'h00;
			addr_r  <= 8'h00;
			oe_r    <= 1'b0;
			rw_r    <= 1'b0;
			mack_r  <= 1'b0;
			seen_r  <= 1'b0;
			req_r   <= 1'b0;
			wv_r    <= 1'b0;
			wd_r    <= 16'h0000;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			lst_r   <= lst_nxt;
			cnt_r   <= cnt_nxt;
			sh_r    <= sh_nxt;
			addr_r  <= addr_nxt;
			oe_r    <= oe_nxt;
			rw_r    <= rw_nxt;
			mack_r  <= mack_nxt;
			seen_r  <= seen_nxt;
			req_r   <= req_nxt;
			wv_r    <= wv_nxt;
			wd_r    <= wd_nxt;
			scl_q_r <= scl_s;
			sda_q_r <= sda_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core write cycle: drain buffer, then wait the cycle time
	assign rd_if.ready = cst_r == C_DRAIN;

	always_comb begin
		cst_nxt  = cst_r;
		tmr_nxt  = tmr_r;
		cack_nxt = cack_r;
		busy_nxt = busy_r;
		case (cst_r)
		C_IDLE: begin
			if (req_s) begin
				cst_nxt  = C_DRAIN;
				busy_nxt = 1'b1;
			end
		end
		C_DRAIN: begin
			if (!rd_if.valid) begin
				cst_nxt = C_WAIT;
				tmr_nxt = '0;
			end
		end
		C_WAIT: begin
			if (tmr_r == TMR_W'(WR_CYCLES - 1)) begin
				cst_nxt  = C_DONE;
				cack_nxt = 1'b1;
			end else begin
				tmr_nxt = tmr_r + TMR_W'(1);
			end
		end
		default: begin
			if (!req_s) begin
				cst_nxt  = C_IDLE;
				cack_nxt = 1'b0;
				busy_nxt = 1'b0;
			end
		end
		endcase
	end

	// Core registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cst_r  <= C_IDLE;
			tmr_r  <= '0;
			cack_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			cst_r  <= cst_nxt;
			tmr_r  <= tmr_nxt;
			cack_r <= cack_nxt;
			busy_r <= busy_nxt;
		end
	end

	// Memory array commit, no reset
	always_ff @(posedge clock) begin
		if (rd_if.ready && rd_if.valid) begin
			mem_r[rd_if.data[FIFO_W-1:DATA_W]] <= rd_if.data[DATA_W-1:0];
		end
	end

	assign write_busy = busy_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	start_dev_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(start && !stop && !busy) |=> (lst_r == L_DEV && cnt_r == 4'h0))
		else $error("start did not open address phase");
	addr_field_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(lst_r == L_DEV_ACK) |-> (sh_r[7:4] == 4'ha && sh_r[3:1] == straps_s))
		else $error("address acknowledged without match");
	nomatch_idle_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(lst_r == L_DEV && rx_done && !match && !start && !stop)
		|=> (lst_r == L_IDLE && !sda_oe))
		else $error("mismatch not returned to standby");
	rw_select_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(lst_r == L_DEV_ACK && scl_fall && !start && !stop)
		|=> (lst_r == (rw_r ? L_RDATA : L_WADDR)))
		else $error("wrong direction after address");
	busy_quiet_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(busy && lst_r == L_IDLE) |=> (lst_r == L_IDLE && !sda_oe))
		else $error("responded during write cycle");
	stop_commit_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(stop && seen_r) |=> req_r [*2])
		else $error("stop after data did not start write");
	page_wrap_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(lst_r == L_WDATA && rx_done && wr_if.ready && !start && !stop)
		|=> (addr_r[7:3] == $past(addr_r[7:3]) &&
		addr_r[2:0] == $past(addr_r[2:0]) + 3'h1 && wv_r))
		else $error("write address not page wrapped");
	read_inc_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(lst_r == L_RDATA && rx_done && !start && !stop)
		|=> (addr_r == $past(addr_r) + 8'h1 && lst_r == L_RD_ACK))
		else $error("read counter not advanced");
	read_end_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(lst_r == L_RD_ACK && scl_fall && !mack_r && !start && !stop)
		|=> (lst_r == L_IDLE && !sda_oe))
		else $error("read continued without acknowledge");
	cycle_len_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(cack_r) |-> ($past(tmr_r) == TMR_W'(WR_CYCLES - 1) && busy_r))
		else $error("write cycle length wrong");
endmodule // setwt_target

// *** tb/setwt_master_model.sv ***
// Behavioural two-wire bus master driving the target's pins.
// Assumes the core clock paces it; sda is the resolved wire level.
`timescale 1ns/10ps
module setwt_master_model #(
	parameter int HALF = 70
) (
	input  wire logic clock,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	localparam int QTR = HALF / 2;

	////////////////////////////////////////
	// Idle bus: clock high, data released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Whole core cycles
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask

	// Start or repeated start, from idle or mid-transfer
	task automatic start();
		sda_low <= 1'b0;
		wt(QTR);
		scl <= 1'b1;
		wt(HALF);
		sda_low <= 1'b1;
		wt(HALF);
		scl <= 1'b0;
		wt(QTR);
	endtask

	// One clock; data set while low, wire sampled at end of high
	task automatic pulse(input logic drive_low, output logic seen);
		sda_low <= drive_low;
		wt(QTR);
		scl <= 1'b1;
		wt(HALF);
		seen = sda;
		scl <= 1'b0;
		wt(QTR);
	endtask

	// Byte out, most significant bit first, then the ninth clock
	task automatic send(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			pulse(~b[i], s);
		pulse(1'b0, s);
		ack = ~s;
	endtask

	// Byte in; low on the ninth clock asks for more
	task automatic recv(input logic more, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			pulse(1'b0, s);
			b[i] = s;
		end
		pulse(more, s);
	endtask

	// Stop condition ends every sequence
	task automatic stop();
		sda_low <= 1'b1;
		wt(QTR);
		scl <= 1'b1;
		wt(HALF);
		sda_low <= 1'b0;
		wt(QTR);
	endtask
endmodule // setwt_master_model

// *** tb/setwt_target_test.sv ***
// Self-checking bench of the two-wire memory target.
// Assumes the master model above; a pull-up holds the data wire high.
`timescale 1ns/10ps
module setwt_target_test;
	import setwt_pkg::*;
	localparam int WRC  = 400;
	localparam int CEIL = 95000;
	logic               clock;
	logic               resetn;
	logic               link_clk;
	logic               scl;
	logic               sda;
	logic               m_low;
	logic               sda_o;
	logic               sda_oe;
	logic               write_busy;
	logic [STRAP_W-1:0] straps;
	int                 n_fail;
	int                 checked;
	int                 cyc;

	// Open-drain wire with pull-up
	assign sda = (m_low || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

	// Clocks, link one offset in phase
	always #5 clock = ~clock;
	initial begin
		link_clk = 1'b0;
		#1.7;
		forever #62.5 link_clk = ~link_clk;
	end

	setwt_target #(
		.WR_CYCLES(WRC)
	) DUT (
		.clock(clock),
		.resetn(resetn),
		.link_clk(link_clk),
		.scl(scl),
		.sda_i(sda),
		.sda_o(sda_o),
		.sda_oe(sda_oe),
		.device_select_straps(straps),
		.write_busy(write_busy)
	);

	setwt_master_model master (
		.clock(clock),
		.sda(sda),
		.scl(scl),
		.sda_low(m_low)
	);

	////////////////////////////////////////
	// Comparison and verdict
	task automatic check(input logic [7:0] seen, input logic [7:0] exp,
			input string what);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t %s got %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Hang guard
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == CEIL) begin
			n_fail++;
			$display("BAD %0t run too long", $time);
			summarize();
		end
	end

	// Device address byte for the current straps
	function automatic logic [7:0] dev(input logic rw);
		return {4'ha, straps, rw};
	endfunction

	////////////////////////////////////////
	// Sequence helpers
	task automatic addr_phase(input logic [7:0] wa);
		logic a;
		master.start();
		master.send(dev(1'b0), a);
		check({7'h0, a}, 8'h01, "write select ack");
		master.send(wa, a);
		check({7'h0, a}, 8'h01, "word address ack");
	endtask

	task automatic wait_ready();
		logic a;
		a = 1'b0;
		for (int k = 0; k < 6 && !a; k++) begin
			master.start();
			master.send(dev(1'b0), a);
			master.stop();
		end
		check({7'h0, a}, 8'h01, "poll after write");
		check({7'h0, write_busy}, 8'h00, "busy cleared");
	endtask

	// Sends n data bytes counting up from d0
	task automatic write_seq(input logic [7:0] wa, input logic [7:0] d0,
			input int n);
		logic a;
		addr_phase(wa);
		for (int i = 0; i < n; i++) begin
			master.send(d0 + 8'(i), a);
			check({7'h0, a}, 8'h01, "data ack");
		end
		master.stop();
		for (int k = 0; k < 100 && write_busy !== 1'b1; k++)
			@(posedge clock);
		check({7'h0, write_busy}, 8'h01, "busy after stop");
		master.start();
		master.send(dev(1'b0), a);
		master.stop();
		check({7'h0, a}, 8'h00, "poll during write");
		wait_ready();
	endtask

	task automatic rand_rd(input logic [7:0] wa);
		logic a;
		addr_phase(wa);
		master.start();
		master.send(dev(1'b1), a);
		check({7'h0, a}, 8'h01, "read select ack");
	endtask

	////////////////////////////////////////
	// Scenarios
	task automatic t_byte();
		logic [7:0] b;
		write_seq(8'h12, 8'h5a, 1);
		rand_rd(8'h12);
		master.recv(1'b0, b);
		check(b, 8'h5a, "random read");
		master.stop();
		$display("test byte write done");
	endtask

	task automatic t_foreign();
		logic [7:0] bad [4];
		logic       a;
		bad = '{{4'hb, straps, 1'b0}, {4'h2, straps, 1'b1},
			{4'ha, straps ^ 3'h1, 1'b0}, {4'ha, straps ^ 3'h4, 1'b1}};
		foreach (bad[i]) begin
			master.start();
			master.send(bad[i], a);
			master.stop();
			check({7'h0, a}, 8'h00, "foreign address");
		end
		$display("test address mismatch done");
	endtask

	task automatic t_page();
		logic [7:0] b;
		logic [7:0] e;
		write_seq(8'h1e, 8'h31, 9);
		rand_rd(8'h18);
		for (int i = 0; i < 8; i++) begin
			e = (i < 6) ? 8'h33 + 8'(i) : ((i == 6) ? 8'h39 : 8'h32);
			master.recv(i < 7, b);
			check(b, e, "page contents");
		end
		master.stop();
		$display("test page write done");
	endtask

	task automatic t_wrap();
		logic [7:0] b;
		logic       a;
		straps <= 3'h2;
		repeat (10) @(posedge clock);
		write_seq(8'hff, 8'hc3, 1);
		write_seq(8'h00, 8'h3c, 1);
		rand_rd(8'hff);
		master.recv(1'b0, b);
		check(b, 8'hc3, "top byte");
		master.stop();
		master.start();
		master.send(dev(1'b1), a);
		check({7'h0, a}, 8'h01, "current read ack");
		master.recv(1'b0, b);
		check(b, 8'h3c, "counter wrap");
		master.stop();
		$display("test counter wrap done");
	endtask

	////////////////////////////////////////
	// Main sequence
	initial begin
		clock = 1'b0;
		resetn = 1'b1;
		straps = 3'h5;
		n_fail = 0;
		checked = 0;
		// Real falling edge, so both domains reset without a link edge
		@(posedge clock);
		resetn <= 1'b0;
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		repeat (100) @(posedge clock);
		t_byte();
		t_foreign();
		t_page();
		t_wrap();
		summarize();
	end
endmodule // setwt_target_test
